/* ecphs_chk.sv */
// Assertion checker for the ECP host pins.
// Bound to ecphs_host by port name.
`timescale 1ns/1ps
`default_nettype none
module ecphs_chk (
    input wire ref_clk, rst_n, ecp_mode_en, fwd_is_cmd, fwd_ready,
    input wire rev_valid, pd_oe, forward_select_line_n, host_strobe_line,
    input wire host_feed_line_n, rev_request_n, busy_line, ack_line_n,
    input wire error_status_line_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_stb;
        $past(rst_n) |-> host_strobe_line == $past(ecp_mode_en);
    endproperty
    a_stb: assert property (p_stb) else $error("strobe level");
    property p_oe; pd_oe |-> rev_request_n; endproperty
    a_oe: assert property (p_oe) else $error("bus clash");
    property p_sel;
        $fell(forward_select_line_n) |-> pd_oe && !$past(busy_line, 3);
    endproperty
    a_sel: assert property (p_sel) else $error("select early");
    property p_rdy; fwd_ready |-> !$past(busy_line, 3); endproperty
    a_rdy: assert property (p_rdy) else $error("ready early");
    property p_rv;
        rev_valid |-> !$past(ack_line_n, 3) ##1 !rev_valid;
    endproperty
    a_rv: assert property (p_rv) else $error("rev pulse");
    property p_fd;
        !host_feed_line_n && !rev_request_n |-> !$past(error_status_line_n, 2);
    endproperty
    a_fd: assert property (p_fd) else $error("feed early");
    property p_cmd;
        pd_oe && !forward_select_line_n |-> host_feed_line_n == !fwd_is_cmd;
    endproperty
    a_cmd: assert property (p_cmd) else $error("cmd mark");
    property p_cmp; !ecp_mode_en [*3] |-> rev_request_n; endproperty
    a_cmp: assert property (p_cmp) else $error("compat reverse");
    c_cmd: cover property (fwd_ready && fwd_is_cmd);
    c_rev: cover property (rev_valid);
    c_cmp: cover property (!host_strobe_line);
endmodule // ecphs_chk
bind ecphs_host ecphs_chk u_chk (.*);
`default_nettype wire

/* ecphs_host.v */
// ECP host handshake engine driving the parallel port pins.
// Assumes pins resolved outside from output enables; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "ecphs_regs.vh"
module ecphs_host (
    input wire ref_clk,
    input wire rst_n,
    input wire ecp_mode_en,
    input wire fwd_valid,
    input wire [7:0] fwd_byte,
    input wire fwd_is_cmd,
    output reg fwd_ready,
    input wire rev_enable,
    output reg [7:0] rev_byte,
    output reg rev_valid,
    output reg sel_ind,
    input wire [7:0] pd_in,
    output reg [7:0] pd_out,
    output reg pd_oe,
    output reg forward_select_line_n,
    output reg host_strobe_line,
    output reg host_feed_line_n,
    output reg rev_request_n,
    input wire busy_line,
    input wire ack_line_n,
    input wire error_status_line_n,
    input wire select_indicator
);
    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam integer SETUP_LAST_I = `ECPHS_SETUP_CYC - 1;
    wire [3:0] setup_last = SETUP_LAST_I[3:0];
    wire [`ECPHS_SYNC_W-1:0] sync_w;
    reg [7:0] pd_meta_q;
    reg [7:0] pd_sync_q;
    reg [2:0] st_q;
    reg [3:0] cnt_q;
    wire busy_s = sync_w[0];
    wire ack_n_s = sync_w[1];
    wire err_n_s = sync_w[2];
    wire sel_s = sync_w[3];
    ecphs_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({select_indicator, error_status_line_n, ack_line_n,
                   busy_line}),
        .rst_val(4'hF),
        .sync_out(sync_w)
    );
    // Data pins, one pair of flops per bit
    genvar b;
    generate
        for (b = 0; b < 8; b = b + 1) begin : g_pd
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pd_meta_q[b] <= 1'b0;
                    pd_sync_q[b] <= 1'b0;
                end else begin
                    pd_meta_q[b] <= pd_in[b];
                    pd_sync_q[b] <= pd_meta_q[b];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Status pins
    // Strobe tracks the mode level through one register, a cycle later
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_ind <= 1'b0;
            host_strobe_line <= 1'b0;
        end else begin
            sel_ind <= sel_s;
            host_strobe_line <= ecp_mode_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Forward setup timer
    // Saturates so a long busy stall cannot wrap it
    wire setup_done = (cnt_q == setup_last);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else if (st_q != `ECPHS_ST_FWD_SET) begin
            cnt_q <= 4'h0;
        end else if (!setup_done) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Forward completion
    // One-cycle pulse once busy is seen low again
    wire fwd_done = (st_q == `ECPHS_ST_FWD_DONE) && !busy_s;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_ready <= 1'b0;
        end else begin
            fwd_ready <= fwd_done;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reverse capture
    // Byte is taken from the synchronised pins when ack is seen low
    wire rev_take = (st_q == `ECPHS_ST_REV_WAIT) && rev_enable &&
                    ecp_mode_en && !ack_n_s;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rev_byte <= 8'h00;
            rev_valid <= 1'b0;
        end else begin
            rev_valid <= rev_take;
            if (rev_take) begin
                rev_byte <= pd_sync_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Handshake engine
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= `ECPHS_ST_IDLE;
            pd_out <= 8'h00;
            pd_oe <= 1'b0;
            forward_select_line_n <= 1'b1;
            host_feed_line_n <= 1'b1;
            rev_request_n <= 1'b1;
        end else begin
            case (st_q)
                `ECPHS_ST_IDLE: begin
                    forward_select_line_n <= 1'b1;
                    host_feed_line_n <= 1'b1;
                    if (ecp_mode_en && rev_enable) begin
                        pd_oe <= 1'b0;
                        rev_request_n <= 1'b0;
                        st_q <= `ECPHS_ST_REV_REQ;
                    end else if (ecp_mode_en && fwd_valid && !fwd_ready) begin
                        // Guard keeps a held request from a second take
                        pd_out <= fwd_byte;
                        pd_oe <= 1'b1;
                        host_feed_line_n <= ~fwd_is_cmd;
                        st_q <= `ECPHS_ST_FWD_SET;
                    end else begin
                        pd_oe <= ecp_mode_en;
                    end
                end
                // Data held while setup runs
                `ECPHS_ST_FWD_SET: begin
                    if (setup_done && !busy_s) begin
                        forward_select_line_n <= 1'b0;
                        st_q <= `ECPHS_ST_FWD_BUSY;
                    end
                end
                `ECPHS_ST_FWD_BUSY: begin
                    if (busy_s) begin
                        forward_select_line_n <= 1'b1;
                        st_q <= `ECPHS_ST_FWD_DONE;
                    end
                end
                `ECPHS_ST_FWD_DONE: begin
                    if (fwd_done) begin
                        st_q <= `ECPHS_ST_IDLE;
                    end
                end
                `ECPHS_ST_REV_REQ: begin
                    if (!err_n_s) begin
                        st_q <= `ECPHS_ST_REV_WAIT;
                    end else if (!rev_enable) begin
                        rev_request_n <= 1'b1;
                        st_q <= `ECPHS_ST_REV_END;
                    end
                end
                `ECPHS_ST_REV_WAIT: begin
                    if (!rev_enable || !ecp_mode_en) begin
                        host_feed_line_n <= 1'b1;
                        rev_request_n <= 1'b1;
                        st_q <= `ECPHS_ST_REV_END;
                    end else begin
                        host_feed_line_n <= 1'b0;
                        if (!ack_n_s) begin
                            host_feed_line_n <= 1'b1;
                            st_q <= `ECPHS_ST_REV_ACK;
                        end
                    end
                end
                `ECPHS_ST_REV_ACK: begin
                    if (ack_n_s) begin
                        st_q <= `ECPHS_ST_REV_WAIT;
                    end
                end
                `ECPHS_ST_REV_END: begin
                    if (err_n_s) begin
                        st_q <= `ECPHS_ST_IDLE;
                    end
                end
                default: begin
                    st_q <= `ECPHS_ST_IDLE;
                end
            endcase
        end
    end
endmodule // ecphs_host
`default_nettype wire

/* ecphs_periph.sv */
// Behavioural ECP peripheral on the host pins.
// Assumes one clock; dly slows its answers.
`timescale 1ns/1ps
`default_nettype none
module ecphs_periph (
    input wire ref_clk, pd_oe, rev_request_n, forward_select_line_n,
    input wire host_feed_line_n,
    input wire [7:0] pd_out,
    output wire [7:0] pd_in,
    output logic busy_line = 1'b0, ack_line_n = 1'b1,
    output logic error_status_line_n = 1'b1, select_indicator = 1'b1
);
    int dly = 0;
    logic drv = 1'b0, cmd = 1'b0;
    logic [7:0] d = 8'h00, got = 8'h00;
    assign pd_in = pd_oe ? pd_out : drv ? d : ~d;
    initial forever begin
        wait (!forward_select_line_n);
        repeat (dly + 1) @(posedge ref_clk);
        got <= pd_in;
        cmd <= !host_feed_line_n;
        busy_line <= 1'b1;
        wait (forward_select_line_n);
        @(posedge ref_clk);
        busy_line <= 1'b0;
    end
    initial forever begin
        wait (!rev_request_n);
        @(posedge ref_clk);
        error_status_line_n <= 1'b0;
        while (!rev_request_n) begin
            @(posedge ref_clk);
            if (!host_feed_line_n) begin
                drv <= 1'b1;
                d <= drv ? d + 8'h01 : 8'h5A;
                repeat (dly + 1) @(posedge ref_clk);
                ack_line_n <= 1'b0;
                wait (host_feed_line_n);
                @(posedge ref_clk);
                ack_line_n <= 1'b1;
            end
        end
        drv <= 1'b0;
        error_status_line_n <= 1'b1;
    end
endmodule // ecphs_periph
`default_nettype wire

/* ecphs_regs.vh */
// Constants for the ECP host-side parallel handshake block.
// Assumes inclusion by the design files of this block only.
`ifndef ECPHS_REGS_VH
`define ECPHS_REGS_VH
// Engine states
`define ECPHS_ST_IDLE 3'h0
`define ECPHS_ST_FWD_SET 3'h1
`define ECPHS_ST_FWD_BUSY 3'h2
`define ECPHS_ST_FWD_DONE 3'h3
`define ECPHS_ST_REV_REQ 3'h4
`define ECPHS_ST_REV_WAIT 3'h5
`define ECPHS_ST_REV_ACK 3'h6
`define ECPHS_ST_REV_END 3'h7
// Data setup time before the forward select goes active, ns
`define ECPHS_SETUP_NS 50
`define ECPHS_CLK_NS 10
`define ECPHS_SETUP_CYC ((`ECPHS_SETUP_NS + `ECPHS_CLK_NS - 1) / `ECPHS_CLK_NS)
`define ECPHS_SYNC_W 4
`endif

/* ecphs_sync.v */
// Two-flop synchronisers for the peripheral-driven pins.
// Assumes asynchronous pin inputs and one clock ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ecphs_regs.vh"
module ecphs_sync (
    input wire ref_clk,
    input wire rst_n,
    input wire [`ECPHS_SYNC_W-1:0] async_in,
    input wire [`ECPHS_SYNC_W-1:0] rst_val,
    output wire [`ECPHS_SYNC_W-1:0] sync_out
);
    reg [`ECPHS_SYNC_W-1:0] meta_q;
    reg [`ECPHS_SYNC_W-1:0] sync_q;
    genvar i;
    generate
        for (i = 0; i < `ECPHS_SYNC_W; i = i + 1) begin : g_bit
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate
    assign sync_out = sync_q;
endmodule // ecphs_sync
`default_nettype wire

/* tb_ecphs.sv */
// Self-checking bench for the ECP host handshake.
// Assumes ecphs_host, ecphs_chk and ecphs_periph.
`timescale 1ns/1ps
`default_nettype none
module tb_ecp_parallel_host_handshake;
    logic ref_clk = 1'b0, rst_n = 1'b0, ecp_mode_en = 1'b1, fwd_valid = 1'b0;
    logic fwd_is_cmd = 1'b0, rev_enable = 1'b0, fwd_ready, rev_valid, sel_ind;
    logic [7:0] fwd_byte = 8'h00, rev_byte, pd_in, pd_out;
    logic pd_oe, forward_select_line_n, host_strobe_line, host_feed_line_n;
    logic rev_request_n, busy_line, ack_line_n, error_status_line_n;
    logic select_indicator;
    int errors = 0, tests_run = 0;
    always #5 ref_clk = ~ref_clk;
    ecphs_host dut (.*);
    ecphs_periph per (.*);
    task automatic chk(input string what, input logic [7:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic fwd_one(input logic [7:0] b, input logic c);
        int n;
        n = 0;
        @(posedge ref_clk);
        fwd_valid <= 1'b1;
        fwd_byte <= b;
        fwd_is_cmd <= c;
        do @(posedge ref_clk); while (fwd_ready !== 1'b1 && ++n < 300);
        fwd_valid <= 1'b0;
        chk("fwd ready", 8'h01, {7'h00, fwd_ready});
        chk("fwd byte", b, per.got);
        chk("cmd mark", {7'h00, c}, {7'h00, per.cmd});
    endtask
    task automatic rev_two();
        int n;
        n = 0;
        @(posedge ref_clk);
        rev_enable <= 1'b1;
        do @(posedge ref_clk); while (rev_valid !== 1'b1 && ++n < 300);
        chk("rev valid", 8'h01, {7'h00, rev_valid});
        chk("rev byte", 8'h5A, rev_byte);
        do @(posedge ref_clk); while (rev_valid !== 1'b1 && ++n < 600);
        chk("rev valid", 8'h01, {7'h00, rev_valid});
        chk("rev byte", 8'h5B, rev_byte);
        rev_enable <= 1'b0;
        do @(posedge ref_clk); while (error_status_line_n !== 1'b1 && ++n < 900);
        repeat (4) @(posedge ref_clk);
        chk("request", 8'h01, {7'h00, rev_request_n});
    endtask
    task automatic mode_flip();
        @(posedge ref_clk);
        ecp_mode_en <= 1'b0;
        rev_enable <= 1'b1;
        per.select_indicator <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("strobe", 8'h00, {7'h00, host_strobe_line});
        chk("refused", 8'h01, {7'h00, rev_request_n});
        chk("select", 8'h00, {7'h00, sel_ind});
        ecp_mode_en <= 1'b1;
        rev_enable <= 1'b0;
        per.select_indicator <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("strobe", 8'h01, {7'h00, host_strobe_line});
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        fwd_one(8'hA5, 1'b0);
        per.dly = 3;
        fwd_one(8'h3C, 1'b1);
        fwd_one(8'hC3, 1'b0);
        rev_two();
        mode_flip();
        chk("select", 8'h01, {7'h00, sel_ind});
        stop_test();
    end
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule // tb_ecp_parallel_host_handshake
`default_nettype wire
